//--- bench/radio_status_readout_bench.sv
// self-checking bench for the radio status register bank
module radio_status_readout_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          sys_clk;
  logic                          reset;
  radio_status_pkg::bus_req_type bus_req;
  logic                          waitrequest_r;
  logic [31:0]                   readdata_r;
  radio_status_pkg::radio_in_type radio_in;
  radio_status_pkg::radio_in_type lvl;
  logic                          wake_event;
  logic                          irq_r;
  logic                          regulator_en_r;
  logic                          retention_hold_r;
  logic [3:0]                    be;
  logic [31:0]                   d;
  int                            fails;
  int                            comparisons;

  // reset rows: index and value expected; rssi 0 at threshold 0 reads as clear channel
  logic [15:0] ri [9] = '{16'hDF3B, 16'hDF3C, 16'hDF3D, 16'hDF40, 16'hDF41, 16'hDF42, 16'hDF43, 16'hDF44, 16'hDF50};
  logic [7:0]  rv [9] = '{8'h01, 8'h10, 8'h94, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00};

  radio_status_readout uut (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .bus_req          (bus_req),
    .waitrequest_r    (waitrequest_r),
    .readdata_r       (readdata_r),
    .radio_in         (radio_in),
    .wake_event       (wake_event),
    .irq_r            (irq_r),
    .regulator_en_r   (regulator_en_r),
    .retention_hold_r (retention_hold_r)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic is_wr, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rdata);
    int n;
    @(posedge sys_clk);
    bus_req <= '{address: {idx, 2'b00}, read: ~is_wr, write: is_wr, byteenable: be, writedata: {24'h0, wd}};
    // waitrequest and read data are taken at the rising edge only
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (waitrequest_r === 1'b0) break;
    end
    if (n == 20) begin
      fails++;
      complete_run();
    end
    rdata = readdata_r;
    bus_req.read  <= 1'b0;
    bus_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    bus(1'b1, idx, wd, x);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] v);
    bus(1'b0, idx, 8'h00, v);
  endtask

  // radio event pulse: 0 state, 1 sync, 2 packet end, 3 address reject, 4 crc match
  task automatic ev(input int kind, input logic [4:0] code);
    radio_status_pkg::radio_in_type p;
    p = lvl;
    case (kind)
      0: begin p.state_valid = 1'b1; p.state_code = code; end
      1: p.sync_seen = 1'b1;
      2: p.pkt_end = 1'b1;
      3: p.addr_reject = 1'b1;
      default: begin p.crc_done = 1'b1; p.crc_match = 1'b1; end
    endcase
    @(posedge sys_clk);
    radio_in <= p;
    @(posedge sys_clk);
    radio_in <= lvl;
  endtask

  task automatic levels(input logic [7:0] rssi, input logic [7:0] pqi);
    lvl.rssi = rssi;
    lvl.pqi  = pqi;
    @(posedge sys_clk);
    radio_in <= lvl;
  endtask

  // watchdog so a stuck handshake still reaches the verdict
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    bus_req = '0;
    be = 4'hF;
    lvl = '0;
    radio_in = '0;
    wake_event = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    check(regulator_en_r, 1'b1);
    for (int i = 0; i < 9; i++) begin
      rd(ri[i], d);
      check(d, {24'h0, rv[i]});
    end
    // read-only state ignores writes, then follows the controller
    wr(16'hDF3B, 8'hFF);
    rd(16'hDF3B, d);
    check(d, 32'h01);
    ev(0, 5'h13);
    rd(16'hDF3B, d);
    check(d, 32'h13);
    ev(1, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h18);
    ev(0, 5'h16);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    rd(16'hDF43, d);
    check(d, 32'h11);
    wr(16'hDF43, 8'h1F);
    rd(16'hDF43, d);
    check(d, 32'h00);
    // crc flag set by a match, cleared on receive entry and restart
    ev(4, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h90);
    ev(0, 5'h0D);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    ev(1, 5'h00);
    ev(3, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    ev(1, 5'h00);
    ev(0, 5'h11);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    ev(4, 5'h00);
    ev(0, 5'h0F);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    // masked sync rise keeps irq low, unmasked packet end raises it
    wr(16'hDF43, 8'h1F);
    wr(16'hDF44, 8'h02);
    ev(0, 5'h13);
    ev(1, 5'h00);
    repeat (2) @(posedge sys_clk);
    check(irq_r, 1'b0);
    ev(2, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    check(irq_r, 1'b1);
    wr(16'hDF43, 8'h02);
    repeat (2) @(posedge sys_clk);
    check(irq_r, 1'b0);
    // carrier, clear channel and preamble quality against thresholds
    wr(16'hDF40, 8'h10);
    levels(8'h20, 8'h05);
    rd(16'hDF3C, d);
    check(d, 32'h60);
    levels(8'hF0, 8'h05);
    rd(16'hDF3C, d);
    check(d, 32'h30);
    wr(16'hDF42, 8'h00);
    levels(8'h20, 8'h04);
    rd(16'hDF3C, d);
    check(d, 32'h50);
    be = 4'h0;
    wr(16'hDF40, 8'h55);
    be = 4'hF;
    // deep modes turn the regulator off and keep register contents
    wr(16'hDF42, 8'h20);
    repeat (3) @(posedge sys_clk);
    check(regulator_en_r, 1'b0);
    check(retention_hold_r, 1'b1);
    rd(16'hDF40, d);
    check(d, 32'h10);
    @(posedge sys_clk);
    wake_event <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(regulator_en_r, 1'b1);
    wr(16'hDF42, 8'hFF);
    repeat (3) @(posedge sys_clk);
    check(regulator_en_r, 1'b0);
    rd(16'hDF42, d);
    check(d, 32'h33);
    rd(16'hDF3D, d);
    check(d, 32'h94);
    // combined assessment mode: a frame in flight holds the channel busy
    levels(8'hF0, 8'h04);
    ev(1, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h08);
    ev(2, 5'h00);
    rd(16'hDF3C, d);
    check(d, 32'h10);
    // mid-run reset brings state, mode and regulator back to reset values
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    check(regulator_en_r, 1'b1);
    rd(16'hDF3B, d);
    check(d, 32'h01);
    rd(16'hDF42, d);
    check(d, 32'h01);
    complete_run();
  end
endmodule // radio_status_readout_bench

//--- hw/radio_status_pkg.sv
// constants, register map and carrier types of the radio status readout block
// Functional notes
// - the radio controller state is readable as a 5-bit code covering sleep, idle, calibration, receive, transmit and error states.
// - after reset the controller state code reads as idle (one) until the controller reports another state.
// - the checksum-match flag (bit 7) shows the latest checksum comparison and clears on entering or restarting receive.
// - the sync/frame flag (bit 3) rises when the sync word is sent or received and falls at the end of the packet.
// - in receive the sync/frame flag falls early on an address-filter reject or on entry to the receive overrun state.
// - in transmit the sync/frame flag falls early on entry to the transmit starve state.
// - the carrier-sense flag (bit 6) is high while the signal strength is above the carrier threshold.
// - the clear-channel flag (bit 4) follows the signal strength being at or below threshold, qualified by the assessment mode.
// - the preamble-quality flag (bit 5) is high while preamble quality is above the programmed quality threshold.
// - an 8-bit read-only test readout of the pll calibration current resets to 0x94.
// - the core regulator is switched off in the two deepest power modes.
// - with the regulator off, register and ram contents are kept while the unregulated supply is present.
package radio_status_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_FSM_STATE  = 16'hDF3B;
  localparam logic [15:0] IDX_PKT_FLAGS  = 16'hDF3C;
  localparam logic [15:0] IDX_PLL_CAL    = 16'hDF3D;
  localparam logic [15:0] IDX_CS_THRESH  = 16'hDF40;
  localparam logic [15:0] IDX_PQ_THRESH  = 16'hDF41;
  localparam logic [15:0] IDX_MODE_CTRL  = 16'hDF42;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hDF43;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hDF44;
  localparam int          ADDR_W         = 18;

  // controller state codes
  localparam logic [4:0] ST_SLEEP       = 5'h00;
  localparam logic [4:0] ST_IDLE        = 5'h01;
  localparam logic [4:0] ST_RX          = 5'h0D;
  localparam logic [4:0] ST_RX_RESTART  = 5'h0F;
  localparam logic [4:0] ST_RX_OVERRUN  = 5'h11;
  localparam logic [4:0] ST_TX          = 5'h13;
  localparam logic [4:0] ST_TX_STARVE   = 5'h16;

  // packet flag bit positions
  localparam int PF_CRC_MATCH = 7;
  localparam int PF_CARRIER   = 6;
  localparam int PF_PREAMBLE  = 5;
  localparam int PF_CLEAR     = 4;
  localparam int PF_SYNC      = 3;

  // mode control fields: cca mode in [1:0], power mode in [5:4]
  localparam int MC_CCA_LO = 0;
  localparam int MC_PWR_LO = 4;

  // channel-assessment modes
  localparam logic [1:0] CCA_ALWAYS   = 2'h0;
  localparam logic [1:0] CCA_RSSI     = 2'h1;
  localparam logic [1:0] CCA_NO_PKT   = 2'h2;
  localparam logic [1:0] CCA_RSSI_PKT = 2'h3;

  // power modes; the two deepest switch the regulator off
  localparam logic [1:0] PWR_ACTIVE     = 2'h0;
  localparam logic [1:0] PWR_LIGHT      = 2'h1;
  localparam logic [1:0] PWR_TIMER_WAKE = 2'h2;
  localparam logic [1:0] PWR_DEEPEST    = 2'h3;

  // interrupt status bits
  localparam int IRQ_N         = 5;
  localparam int IRQ_SYNC_RISE = 0;
  localparam int IRQ_PKT_END   = 1;
  localparam int IRQ_CRC_MATCH = 2;
  localparam int IRQ_OVERRUN   = 3;
  localparam int IRQ_STARVE    = 4;

  // reset values
  localparam logic [4:0] RST_STATE     = ST_IDLE;
  localparam logic [7:0] RST_PLL_CAL   = 8'h94;
  localparam logic [7:0] RST_CS_THRESH = 8'h00;
  localparam logic [7:0] RST_PQ_THRESH = 8'h04;
  localparam logic [7:0] RST_MODE_CTRL = 8'h01;

  // status coming from the radio core
  typedef struct packed {
    logic       state_valid;
    logic [4:0] state_code;
    logic       crc_done;
    logic       crc_match;
    logic       sync_seen;
    logic       pkt_end;
    logic       addr_reject;
    logic [7:0] rssi;
    logic [7:0] pqi;
    logic       pll_cal_valid;
    logic [7:0] pll_cal;
  } radio_in_type;

  // avalon request from the processor side
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } bus_req_type;

endpackage

//--- hw/radio_status_readout.sv
// radio status register bank with avalon-mm slave, interrupts and regulator control
module radio_status_readout (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire radio_status_pkg::bus_req_type bus_req,
  output logic                               waitrequest_r,
  output logic [31:0]                        readdata_r,
  input  wire radio_status_pkg::radio_in_type radio_in,
  input  wire logic                          wake_event,
  output logic                               irq_r,
  output logic                               regulator_en_r,
  output logic                               retention_hold_r
);

  logic [4:0]                        state_r;
  logic [7:0]                        pkt_flags_r;
  logic [7:0]                        pll_cal_r;
  logic [7:0]                        cs_thresh_r;
  logic [7:0]                        pq_thresh_r;
  logic [7:0]                        mode_ctrl_r;
  logic [radio_status_pkg::IRQ_N-1:0] irq_mask_r;
  logic [radio_status_pkg::IRQ_N-1:0] irq_status;
  logic [radio_status_pkg::IRQ_N-1:0] irq_set;
  logic [radio_status_pkg::IRQ_N-1:0] irq_clr;
  logic [31:0]                       readdata_nxt;
  logic [15:0]                       reg_idx;
  logic                              wr_take;
  logic                              state_load;
  logic                              enter_rx;
  logic                              enter_overrun;
  logic                              enter_starve;
  logic                              sync_drop;
  logic                              in_rx;
  logic                              in_tx;
  logic                              carrier_nxt;
  logic                              below_nxt;
  logic                              clear_nxt;
  logic [1:0]                        cca_mode;
  logic [1:0]                        pwr_mode;

  assign reg_idx  = bus_req.address[radio_status_pkg::ADDR_W-1:2];
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_take  = bus_req.write && !waitrequest_r && bus_req.byteenable[0];
  assign cca_mode = mode_ctrl_r[radio_status_pkg::MC_CCA_LO +: 2];
  assign pwr_mode = mode_ctrl_r[radio_status_pkg::MC_PWR_LO +: 2];

  // controller state tracking and entry decode
  assign state_load    = radio_in.state_valid && (radio_in.state_code != state_r);
  assign enter_rx      = state_load && (radio_in.state_code == radio_status_pkg::ST_RX
                         || radio_in.state_code == radio_status_pkg::ST_RX_RESTART);
  assign enter_overrun = state_load && (radio_in.state_code == radio_status_pkg::ST_RX_OVERRUN);
  assign enter_starve  = state_load && (radio_in.state_code == radio_status_pkg::ST_TX_STARVE);
  assign in_rx         = (state_r == radio_status_pkg::ST_RX);
  assign in_tx         = (state_r == radio_status_pkg::ST_TX);

  // state code register; software writes never reach it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= radio_status_pkg::RST_STATE;
    end else if (radio_in.state_valid) begin
      state_r <= radio_in.state_code;
    end
  end

  // sync/frame flag drop conditions; any drop beats a simultaneous rise
  assign sync_drop = radio_in.pkt_end
                     || (in_rx && radio_in.addr_reject) || enter_overrun
                     || enter_starve;

  // signal-strength comparisons; rssi is two's complement
  assign carrier_nxt = $signed(radio_in.rssi) > $signed(cs_thresh_r);
  assign below_nxt   = !carrier_nxt;

  // clear channel per assessment mode; in the two packet modes a frame in flight means busy
  always_comb begin
    case (cca_mode)
      radio_status_pkg::CCA_ALWAYS:   clear_nxt = 1'b1;
      radio_status_pkg::CCA_RSSI:     clear_nxt = below_nxt;
      radio_status_pkg::CCA_NO_PKT:   clear_nxt = !pkt_flags_r[radio_status_pkg::PF_SYNC];
      radio_status_pkg::CCA_RSSI_PKT: clear_nxt = below_nxt && !pkt_flags_r[radio_status_pkg::PF_SYNC];
      default:                        clear_nxt = 1'b1;
    endcase
  end

  // packet flags in one process so the byte has a single driver;
  // a finishing checksum comparison wins over the receive-entry clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pkt_flags_r <= 8'h00;
    end else begin
      if (radio_in.crc_done) begin
        pkt_flags_r[radio_status_pkg::PF_CRC_MATCH] <= radio_in.crc_match;
      end else if (enter_rx) begin
        pkt_flags_r[radio_status_pkg::PF_CRC_MATCH] <= 1'b0;
      end
      if (sync_drop) begin
        pkt_flags_r[radio_status_pkg::PF_SYNC] <= 1'b0;
      end else if (radio_in.sync_seen) begin
        pkt_flags_r[radio_status_pkg::PF_SYNC] <= 1'b1;
      end
      pkt_flags_r[radio_status_pkg::PF_CARRIER]  <= carrier_nxt;
      pkt_flags_r[radio_status_pkg::PF_PREAMBLE] <= radio_in.pqi > pq_thresh_r;
      pkt_flags_r[radio_status_pkg::PF_CLEAR]    <= clear_nxt;
      pkt_flags_r[2:0]                           <= 3'h0;
    end
  end

  // pll calibration readout, test only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pll_cal_r <= radio_status_pkg::RST_PLL_CAL;
    end else if (radio_in.pll_cal_valid) begin
      pll_cal_r <= radio_in.pll_cal;
    end
  end

  // software configuration registers; the wake event returns to active mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cs_thresh_r <= radio_status_pkg::RST_CS_THRESH;
      pq_thresh_r <= radio_status_pkg::RST_PQ_THRESH;
      mode_ctrl_r <= radio_status_pkg::RST_MODE_CTRL;
      irq_mask_r  <= '0;
    end else begin
      if (wr_take && reg_idx == radio_status_pkg::IDX_CS_THRESH) begin
        cs_thresh_r <= bus_req.writedata[7:0];
      end
      if (wr_take && reg_idx == radio_status_pkg::IDX_PQ_THRESH) begin
        pq_thresh_r <= bus_req.writedata[7:0];
      end
      if (wake_event) begin
        mode_ctrl_r[radio_status_pkg::MC_PWR_LO +: 2] <= radio_status_pkg::PWR_ACTIVE;
      end else if (wr_take && reg_idx == radio_status_pkg::IDX_MODE_CTRL) begin
        mode_ctrl_r <= bus_req.writedata[7:0] & 8'h33;
      end
      if (wr_take && reg_idx == radio_status_pkg::IDX_IRQ_MASK) begin
        irq_mask_r <= bus_req.writedata[radio_status_pkg::IRQ_N-1:0];
      end
    end
  end

  // regulator off in the two deepest modes; nothing is reset by it, so state is kept
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regulator_en_r   <= 1'b1;
      retention_hold_r <= 1'b0;
    end else begin
      regulator_en_r   <= !(pwr_mode == radio_status_pkg::PWR_TIMER_WAKE
                            || pwr_mode == radio_status_pkg::PWR_DEEPEST);
      retention_hold_r <= (pwr_mode == radio_status_pkg::PWR_TIMER_WAKE
                           || pwr_mode == radio_status_pkg::PWR_DEEPEST);
    end
  end

  // interrupt events and write-one-to-clear
  assign irq_set[radio_status_pkg::IRQ_SYNC_RISE] = radio_in.sync_seen && !sync_drop
                                                  && !pkt_flags_r[radio_status_pkg::PF_SYNC];
  assign irq_set[radio_status_pkg::IRQ_PKT_END]   = radio_in.pkt_end;
  assign irq_set[radio_status_pkg::IRQ_CRC_MATCH] = radio_in.crc_done && radio_in.crc_match;
  assign irq_set[radio_status_pkg::IRQ_OVERRUN]   = enter_overrun;
  assign irq_set[radio_status_pkg::IRQ_STARVE]    = enter_starve;
  assign irq_clr = (wr_take && reg_idx == radio_status_pkg::IDX_IRQ_STATUS)
                   ? bus_req.writedata[radio_status_pkg::IRQ_N-1:0] : '0;

  for (genvar i = 0; i < radio_status_pkg::IRQ_N; i++) begin : g_irq
    sticky_bit u_sticky (
      .sys_clk (sys_clk),
      .reset   (reset),
      .set     (irq_set[i]),
      .clear   (irq_clr[i]),
      .flag_r  (irq_status[i])
    );
  end

  // one level interrupt, high while any unmasked status bit is set
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status & irq_mask_r);
    end
  end

  // read mux; unmapped addresses read zero and high bits are always zero
  always_comb begin
    readdata_nxt = 32'h0000_0000;
    case (reg_idx)
      radio_status_pkg::IDX_FSM_STATE:  readdata_nxt[4:0] = state_r;
      radio_status_pkg::IDX_PKT_FLAGS:  readdata_nxt[7:0] = pkt_flags_r;
      radio_status_pkg::IDX_PLL_CAL:    readdata_nxt[7:0] = pll_cal_r;
      radio_status_pkg::IDX_CS_THRESH:  readdata_nxt[7:0] = cs_thresh_r;
      radio_status_pkg::IDX_PQ_THRESH:  readdata_nxt[7:0] = pq_thresh_r;
      radio_status_pkg::IDX_MODE_CTRL:  readdata_nxt[7:0] = mode_ctrl_r;
      radio_status_pkg::IDX_IRQ_STATUS: readdata_nxt[radio_status_pkg::IRQ_N-1:0] = irq_status;
      radio_status_pkg::IDX_IRQ_MASK:   readdata_nxt[radio_status_pkg::IRQ_N-1:0] = irq_mask_r;
      default:                          readdata_nxt = 32'h0000_0000;
    endcase
  end

  // bus handshake: waitrequest drops for exactly one cycle per request,
  // one edge after the request is seen, so every access takes two edges
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h0000_0000;
    end else begin
      waitrequest_r <= !((bus_req.read || bus_req.write) && waitrequest_r);
      if (bus_req.read && waitrequest_r) begin
        readdata_r <= readdata_nxt;
      end
    end
  end

  // helper: has the controller ever reported a state since reset
  logic state_seen_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_seen_r <= 1'b0;
    end else if (radio_in.state_valid) begin
      state_seen_r <= 1'b1;
    end
  end

  property p_state_follow;
    @(posedge sys_clk) disable iff (reset)
      radio_in.state_valid |=> state_r == $past(radio_in.state_code);
  endproperty
  a_state_follow: assert property (p_state_follow)
    else $error("state code did not follow the controller");

  property p_reset_idle;
    @(posedge sys_clk) disable iff (reset)
      !state_seen_r |-> state_r == radio_status_pkg::ST_IDLE;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("state code not idle before first report");

  property p_zero_bits;
    @(posedge sys_clk) disable iff (reset)
      !waitrequest_r && $past(bus_req.read) |-> readdata_r[31:8] == 24'h000000
        && (!($past(reg_idx) == radio_status_pkg::IDX_FSM_STATE) || readdata_r[7:5] == 3'h0)
        && (!($past(reg_idx) == radio_status_pkg::IDX_PKT_FLAGS) || readdata_r[2:0] == 3'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unused read bits not zero");

  property p_crc_clear;
    @(posedge sys_clk) disable iff (reset)
      enter_rx && !radio_in.crc_done |=> !pkt_flags_r[radio_status_pkg::PF_CRC_MATCH];
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("checksum flag not cleared on receive entry");

  property p_sync_rise;
    @(posedge sys_clk) disable iff (reset)
      radio_in.sync_seen && !sync_drop |=> pkt_flags_r[radio_status_pkg::PF_SYNC];
  endproperty
  a_sync_rise: assert property (p_sync_rise)
    else $error("sync flag did not rise");

  property p_sync_drop;
    @(posedge sys_clk) disable iff (reset)
      enter_overrun || enter_starve || (in_rx && radio_in.addr_reject) || radio_in.pkt_end
        |=> !pkt_flags_r[radio_status_pkg::PF_SYNC];
  endproperty
  a_sync_drop: assert property (p_sync_drop)
    else $error("sync flag did not drop");

  property p_carrier;
    @(posedge sys_clk) disable iff (reset)
      !$past(reset) |-> pkt_flags_r[radio_status_pkg::PF_CARRIER]
        == ($signed($past(radio_in.rssi)) > $signed($past(cs_thresh_r)));
  endproperty
  a_carrier: assert property (p_carrier)
    else $error("carrier flag does not match signal strength");

  property p_pll_load;
    @(posedge sys_clk) disable iff (reset)
      radio_in.pll_cal_valid |=> pll_cal_r == $past(radio_in.pll_cal);
  endproperty
  a_pll_load: assert property (p_pll_load)
    else $error("pll readout not loaded");

  property p_regulator;
    @(posedge sys_clk) disable iff (reset)
      pwr_mode[1] |=> !regulator_en_r && retention_hold_r;
  endproperty
  a_regulator: assert property (p_regulator)
    else $error("regulator on in a deep power mode");

  property p_bus_answer;
    @(posedge sys_clk) disable iff (reset)
      (bus_req.read || bus_req.write) && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_irq_level;
    @(posedge sys_clk) disable iff (reset)
      ##1 irq_r == |($past(irq_status) & $past(irq_mask_r));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output does not follow masked status");

endmodule // radio_status_readout

//--- hw/sticky_bit.sv
// one sticky status bit, set by hardware, cleared by software
module sticky_bit (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag_r
);

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clear) begin
      flag_r <= 1'b0;
    end
  end

endmodule // sticky_bit
